// [pkg/daq_timing_pkg.sv]
// Purpose: Shared constants and types for the timing router.
// Assumes: Role and select codes are held as level configuration.
// Notes: Line indices address two-bit role fields in the role vector.
package daq_timing_pkg;
    localparam int NUM_LINES = 6;
    localparam int LINE_TICK = 0;
    localparam int LINE_ACQ = 1;
    localparam int LINE_CONV = 2;
    localparam int LINE_SCAN = 3;
    localparam int LINE_OUT = 4;
    localparam int LINE_UPD = 5;
    localparam int MAX_SLAVES = 3;
    localparam logic [1:0] ROLE_OFF = 2'h0;
    localparam logic [1:0] ROLE_MASTER = 2'h1;
    localparam logic [1:0] ROLE_SLAVE = 2'h2;
    localparam logic [1:0] TICK_INT = 2'h0;
    localparam logic [1:0] TICK_EXT = 2'h1;
    localparam logic [1:0] TICK_SHARED = 2'h2;
    localparam logic [1:0] AUX0_OFF = 2'h0;
    localparam logic [1:0] AUX0_CONV = 2'h1;
    localparam logic [1:0] AUX0_SCAN = 2'h2;
    localparam logic [1:0] TRIG_SW = 2'h0;
    localparam logic [1:0] TRIG_ANALOG = 2'h1;
    localparam logic [1:0] TRIG_DIGITAL = 2'h2;
    localparam logic [1:0] TRIG_SHARED = 2'h3;
    localparam int INT_TICK_HZ = 40_000_000;
    localparam int EXT_TICK_MIN_HZ = 1_000_000;
    localparam int EXT_TICK_MAX_HZ = 40_000_000;
    localparam int CORE_CLK_PERIOD_NS = 10;
    localparam int AUX0_SCAN_MIN_TICKS = 2;
    localparam int NUM_PINS = 9;
    localparam int PIN_AUX0 = 0;
    localparam int PIN_AUX1 = 1;
    localparam int PIN_ACQ_EXT = 2;
    localparam int PIN_OUT_EXT = 3;
    localparam int PIN_SH_ACQ = 4;
    localparam int PIN_SH_CONV = 5;
    localparam int PIN_SH_SCAN = 6;
    localparam int PIN_SH_OUT = 7;
    localparam int PIN_SH_UPD = 8;
    localparam int CAL_BANKS = 4;
    localparam logic [1:0] CAL_FACTORY_BANK = 2'h0;
    localparam int DATE_W = 16;
    localparam int TEMP_W = 8;
    localparam logic [11:0] RST_ROLES = 12'h000;
    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_LOAD = 3'b010,
        CAL_SAVE = 3'b100
    } cal_state_t;
    typedef struct packed {
        logic en;
        logic acq_sw;
        logic out_sw;
        logic [11:0] roles;
        logic [1:0] aux0_mode;
        logic aux1_upd;
        logic [1:0] acq_sel;
        logic [1:0] out_sel;
        logic [1:0] trig_mode;
    } cfg_t;
endpackage

// [rtl/daq_timing_sync_router.sv]
// Purpose: Routes tick, trigger, conversion, scan and update signals.
// Assumes: i_tick_clk is the selected tick clock from an outside clock mux.
// Notes: Configuration is quasi-static; it crosses by two flip-flops.
//
// Summary of operation
// - One selected tick clock serves acquisition and output paths together.
// - External conversion strobe is accepted only on auxiliary input zero.
// - External conversion mode silences scan counter and internal scan pulses.
// - External conversion mode ignores acquisition trigger and trigger mode.
// - Aux zero serves conversion or scan, never both at once.
// - External update strobe comes only from auxiliary input one.
// - Shared lines are bidirectional: one master, up to three slaves.
// - Tick master drives its tick out; tick slave uses received tick.
// - Acquisition trigger master drives it; slave uses received line.
// - Conversion master drives its strobe; slave uses received line.
// - Scan master drives its pulse; slave uses received line.
// - Output trigger master drives it; slave uses received line.
// - Update master drives its strobe; slave uses received line.
// - Each of six timing signals routes to the bus independently.
// - Master or slave role is chosen per timing signal.
// - Reset returns every selection to internal sources.
// - Trigger echoes follow the selected acquisition and output triggers.
// - One factory bank plus three user banks; any bank loads.
// - Trim constants are reloaded after power before calibrated operation.
// - Saving a user bank stores date and temperature alongside.
// - In external conversion mode, each aux zero rising edge makes exactly one conversion request.
// - Scan pulse is synchronous to the selected tick clock.
`timescale 1ns/1ns
module daq_timing_sync_router (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_core_en,
    input wire logic i_tick_clk,
    input wire logic [1:0] i_tick_sel,
    input wire logic [11:0] i_sync_roles,
    input wire logic [1:0] i_aux0_mode,
    input wire logic i_aux1_update,
    input wire logic [1:0] i_acq_trig_sel,
    input wire logic [1:0] i_out_trig_sel,
    input wire logic [1:0] i_trig_mode,
    input wire logic i_acq_sw_trigger,
    input wire logic i_out_sw_trigger,
    input wire logic [1:0] i_cal_bank_sel,
    input wire logic i_cal_load,
    input wire logic i_cal_save,
    input wire logic i_cal_done,
    input wire logic [daq_timing_pkg::DATE_W-1:0] i_cal_date,
    input wire logic [daq_timing_pkg::TEMP_W-1:0] i_cal_temp,
    input wire logic i_int_conv,
    input wire logic i_int_scan,
    input wire logic i_int_update,
    input wire logic i_acq_analog_trig,
    input wire logic i_out_analog_trig,
    input wire logic [1:0] i_aux_function_input,
    input wire logic i_acq_ext_trigger_in,
    input wire logic i_out_ext_trigger_in,
    input wire logic i_shared_acq_trigger_line,
    input wire logic i_shared_conversion_line,
    input wire logic i_shared_scan_line,
    input wire logic i_shared_out_trigger_line,
    input wire logic i_shared_update_line,
    output logic [1:0] o_tick_select,
    output logic o_shared_tick_line_oe,
    output logic o_shared_acq_trigger_line,
    output logic o_shared_acq_trigger_line_oe,
    output logic o_shared_conversion_line,
    output logic o_shared_conversion_line_oe,
    output logic o_shared_scan_line,
    output logic o_shared_scan_line_oe,
    output logic o_shared_out_trigger_line,
    output logic o_shared_out_trigger_line_oe,
    output logic o_shared_update_line,
    output logic o_shared_update_line_oe,
    output logic o_conversion_strobe,
    output logic o_scan_begin,
    output logic o_scan_counter_en,
    output logic o_update_strobe,
    output logic o_acq_trigger,
    output logic o_output_trigger,
    output logic [1:0] o_trig_mode,
    output logic o_acq_trigger_echo,
    output logic o_out_trigger_echo,
    output logic o_cal_load_req,
    output logic o_cal_save_req,
    output logic [1:0] o_cal_bank,
    output logic [daq_timing_pkg::DATE_W-1:0] o_cal_date,
    output logic [daq_timing_pkg::TEMP_W-1:0] o_cal_temp,
    output logic o_cal_valid
);
    import daq_timing_pkg::*;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic [1:0] role_of(input logic [11:0] roles, input int idx);
        role_of = roles[2*idx +: 2];
    endfunction

    function automatic logic rise(input logic cur, input logic prev);
        rise = cur & ~prev;
    endfunction

    function automatic logic sel4(input logic [1:0] sel, input logic [3:0] src);
        sel4 = src[sel];
    endfunction

    // ------------------------------------------------------------
    // Core clock domain: configuration and calibration
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] tick_sel;
        logic tick_oe;
        cfg_t cfg;
        cal_state_t cal;
        logic [1:0] bank;
        logic valid;
        logic [DATE_W-1:0] date;
        logic [TEMP_W-1:0] temp;
    } core_t;

    core_t c;
    core_t next_c;

    always_comb begin
        next_c = c;
        next_c.cfg.en = i_core_en;
        if (i_core_en) begin
            if (role_of(i_sync_roles, LINE_TICK) == ROLE_SLAVE) begin
                next_c.tick_sel = TICK_SHARED;
            end else if (i_tick_sel == TICK_EXT) begin
                next_c.tick_sel = TICK_EXT;
            end else begin
                next_c.tick_sel = TICK_INT;
            end
            next_c.tick_oe = role_of(i_sync_roles, LINE_TICK) == ROLE_MASTER;
            next_c.cfg.roles = i_sync_roles;
            if (i_aux0_mode == AUX0_CONV || i_aux0_mode == AUX0_SCAN) begin
                next_c.cfg.aux0_mode = i_aux0_mode;
            end else begin
                next_c.cfg.aux0_mode = AUX0_OFF;
            end
            next_c.cfg.aux1_upd = i_aux1_update;
            next_c.cfg.acq_sel = i_acq_trig_sel;
            next_c.cfg.out_sel = i_out_trig_sel;
            next_c.cfg.trig_mode = i_trig_mode;
            next_c.cfg.acq_sw = i_acq_sw_trigger;
            next_c.cfg.out_sw = i_out_sw_trigger;
            unique case (c.cal)
                CAL_IDLE: begin
                    if (i_cal_save && i_cal_bank_sel != CAL_FACTORY_BANK) begin
                        next_c.cal = CAL_SAVE;
                        next_c.bank = i_cal_bank_sel;
                        next_c.date = i_cal_date;
                        next_c.temp = i_cal_temp;
                    end else if (i_cal_load) begin
                        next_c.cal = CAL_LOAD;
                        next_c.bank = i_cal_bank_sel;
                        next_c.valid = 1'b0;
                    end
                end
                CAL_LOAD: begin
                    if (i_cal_done) begin
                        next_c.cal = CAL_IDLE;
                        next_c.valid = 1'b1;
                    end
                end
                CAL_SAVE: begin
                    if (i_cal_done) begin
                        next_c.cal = CAL_IDLE;
                    end
                end
                default: begin
                    next_c.cal = CAL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            c <= '0;
            c.tick_sel <= TICK_INT;
            c.cfg.roles <= RST_ROLES;
            c.cal <= CAL_LOAD;
            c.bank <= CAL_FACTORY_BANK;
        end else begin
            c <= next_c;
        end
    end

    assign o_tick_select = c.tick_sel;
    assign o_shared_tick_line_oe = c.tick_oe;
    assign o_cal_load_req = c.cal == CAL_LOAD;
    assign o_cal_save_req = c.cal == CAL_SAVE;
    assign o_cal_bank = c.bank;
    assign o_cal_date = c.date;
    assign o_cal_temp = c.temp;
    assign o_cal_valid = c.valid;

    tick_slave_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_core_en && role_of(i_sync_roles, LINE_TICK) == ROLE_SLAVE
        |=> o_tick_select == TICK_SHARED && !o_shared_tick_line_oe)
        else $error("Tick slave did not select the shared tick line.");

    factory_guard_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_core_en && c.cal == CAL_IDLE && i_cal_save && !i_cal_load
        && i_cal_bank_sel == CAL_FACTORY_BANK |=> !o_cal_save_req)
        else $error("Save to the factory bank was not refused.");

    save_stamp_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_core_en && c.cal == CAL_IDLE && i_cal_save && i_cal_bank_sel != CAL_FACTORY_BANK
        |=> o_cal_save_req && o_cal_date == $past(i_cal_date)
        && o_cal_temp == $past(i_cal_temp) && o_cal_bank == $past(i_cal_bank_sel))
        else $error("Save did not carry its date and temperature.");

    reload_first_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $rose(o_cal_valid) |-> $past(o_cal_load_req) && $past(i_cal_done))
        else $error("Calibration valid without a completed load.");

    // ------------------------------------------------------------
    // Tick clock domain: signal routing
    // ------------------------------------------------------------
    typedef struct packed {
        cfg_t c1;
        cfg_t c2;
        logic [NUM_PINS-1:0] p1;
        logic [NUM_PINS-1:0] p2;
        logic [NUM_PINS-1:0] pp;
        logic conv;
        logic scan;
        logic scan_en;
        logic upd;
        logic acq;
        logic out;
        logic [1:0] mode;
        logic [NUM_LINES-1:0] sh_out;
        logic [NUM_LINES-1:0] sh_oe;
    } tick_t;

    tick_t t;
    tick_t next_t;
    logic [NUM_PINS-1:0] pins;
    logic ext_conv;
    logic [NUM_PINS-1:0] edge_hit;

    assign pins = {i_shared_update_line, i_shared_out_trigger_line, i_shared_scan_line,
        i_shared_conversion_line, i_shared_acq_trigger_line, i_out_ext_trigger_in,
        i_acq_ext_trigger_in, i_aux_function_input};
    assign ext_conv = t.c2.aux0_mode == AUX0_CONV;
    assign edge_hit = t.p2 & ~t.pp;

    always_comb begin
        logic acq_src;
        logic out_src;
        acq_src = 1'b0;
        out_src = 1'b0;
        next_t = t;
        next_t.c1 = c.cfg;
        next_t.c2 = t.c1;
        next_t.p1 = pins;
        next_t.p2 = t.p1;
        if (t.c2.en) begin
            next_t.pp = t.p2;
            if (ext_conv) begin
                next_t.conv = rise(t.p2[PIN_AUX0], t.pp[PIN_AUX0]);
            end else if (role_of(t.c2.roles, LINE_CONV) == ROLE_SLAVE) begin
                next_t.conv = edge_hit[PIN_SH_CONV];
            end else begin
                next_t.conv = i_int_conv;
            end
            if (t.c2.aux0_mode == AUX0_SCAN) begin
                next_t.scan = edge_hit[PIN_AUX0];
            end else if (ext_conv) begin
                next_t.scan = 1'b0;
            end else if (role_of(t.c2.roles, LINE_SCAN) == ROLE_SLAVE) begin
                next_t.scan = edge_hit[PIN_SH_SCAN];
            end else begin
                next_t.scan = i_int_scan;
            end
            next_t.scan_en = t.c2.aux0_mode == AUX0_OFF
                && role_of(t.c2.roles, LINE_SCAN) != ROLE_SLAVE;
            if (t.c2.aux1_upd) begin
                next_t.upd = edge_hit[PIN_AUX1];
            end else if (role_of(t.c2.roles, LINE_UPD) == ROLE_SLAVE) begin
                next_t.upd = edge_hit[PIN_SH_UPD];
            end else begin
                next_t.upd = i_int_update;
            end
            if (role_of(t.c2.roles, LINE_ACQ) == ROLE_SLAVE) begin
                acq_src = t.p2[PIN_SH_ACQ];
            end else begin
                acq_src = sel4(t.c2.acq_sel, {t.p2[PIN_SH_ACQ], t.p2[PIN_ACQ_EXT],
                    i_acq_analog_trig, t.c2.acq_sw});
            end
            if (role_of(t.c2.roles, LINE_OUT) == ROLE_SLAVE) begin
                out_src = t.p2[PIN_SH_OUT];
            end else begin
                out_src = sel4(t.c2.out_sel, {t.p2[PIN_SH_OUT], t.p2[PIN_OUT_EXT],
                    i_out_analog_trig, t.c2.out_sw});
            end
            next_t.acq = ext_conv ? 1'b0 : acq_src;
            next_t.mode = ext_conv ? 2'h0 : t.c2.trig_mode;
            next_t.out = out_src;
            next_t.sh_out = '0;
            next_t.sh_out[LINE_ACQ] = acq_src;
            next_t.sh_out[LINE_CONV] = next_t.conv;
            next_t.sh_out[LINE_SCAN] = next_t.scan;
            next_t.sh_out[LINE_OUT] = out_src;
            next_t.sh_out[LINE_UPD] = next_t.upd;
            next_t.sh_oe = '0;
            for (int k = 1; k < NUM_LINES; k++) begin
                next_t.sh_oe[k] = role_of(t.c2.roles, k) == ROLE_MASTER;
            end
        end
    end

    always_ff @(posedge i_tick_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            t <= '0;
        end else begin
            t <= next_t;
        end
    end

    assign o_conversion_strobe = t.conv;
    assign o_scan_begin = t.scan;
    assign o_scan_counter_en = t.scan_en;
    assign o_update_strobe = t.upd;
    assign o_acq_trigger = t.acq;
    assign o_output_trigger = t.out;
    assign o_trig_mode = t.mode;
    assign o_acq_trigger_echo = t.acq;
    assign o_out_trigger_echo = t.out;
    assign o_shared_acq_trigger_line = t.sh_out[LINE_ACQ];
    assign o_shared_acq_trigger_line_oe = t.sh_oe[LINE_ACQ];
    assign o_shared_conversion_line = t.sh_out[LINE_CONV];
    assign o_shared_conversion_line_oe = t.sh_oe[LINE_CONV];
    assign o_shared_scan_line = t.sh_out[LINE_SCAN];
    assign o_shared_scan_line_oe = t.sh_oe[LINE_SCAN];
    assign o_shared_out_trigger_line = t.sh_out[LINE_OUT];
    assign o_shared_out_trigger_line_oe = t.sh_oe[LINE_OUT];
    assign o_shared_update_line = t.sh_out[LINE_UPD];
    assign o_shared_update_line_oe = t.sh_oe[LINE_UPD];

    aux0_edge_a: assert property (@(posedge i_tick_clk) disable iff (!i_nrst)
        t.c2.en && ext_conv |=> o_conversion_strobe == $past(edge_hit[PIN_AUX0]))
        else $error("Aux zero edge and conversion request disagree.");

    conv_only_aux0_a: assert property (@(posedge i_tick_clk) disable iff (!i_nrst)
        t.c2.en && ext_conv && !edge_hit[PIN_AUX0] && (i_int_conv || edge_hit[PIN_SH_CONV])
        |=> !o_conversion_strobe)
        else $error("Conversion taken from a source other than aux zero.");

    scan_quiet_a: assert property (@(posedge i_tick_clk) disable iff (!i_nrst)
        t.c2.en && ext_conv |=> !o_scan_begin && !o_scan_counter_en)
        else $error("Scan logic active in external conversion mode.");

    trig_ignored_a: assert property (@(posedge i_tick_clk) disable iff (!i_nrst)
        t.c2.en && ext_conv |=> !o_acq_trigger && o_trig_mode == 2'h0 && !o_acq_trigger_echo)
        else $error("Trigger active in external conversion mode.");

    aux0_scan_a: assert property (@(posedge i_tick_clk) disable iff (!i_nrst)
        t.c2.en && t.c2.aux0_mode == AUX0_SCAN && edge_hit[PIN_AUX0] && !i_int_conv
        && role_of(t.c2.roles, LINE_CONV) != ROLE_SLAVE |=> o_scan_begin && !o_conversion_strobe)
        else $error("Aux zero drove conversion while in scan mode.");

    aux1_update_a: assert property (@(posedge i_tick_clk) disable iff (!i_nrst)
        t.c2.en && t.c2.aux1_upd |=> o_update_strobe == $past(edge_hit[PIN_AUX1]))
        else $error("Update strobe does not follow aux one edges.");

    slave_acq_a: assert property (@(posedge i_tick_clk) disable iff (!i_nrst)
        t.c2.en && !ext_conv && role_of(t.c2.roles, LINE_ACQ) == ROLE_SLAVE
        |=> o_acq_trigger == $past(t.p2[PIN_SH_ACQ]) && !o_shared_acq_trigger_line_oe)
        else $error("Acquisition trigger slave ignored the shared line.");

    line_oe_a: assert property (@(posedge i_tick_clk) disable iff (!i_nrst)
        t.c2.en && role_of(t.c2.roles, LINE_UPD) == ROLE_OFF ##1 t.c2.en
        && role_of(t.c2.roles, LINE_UPD) == ROLE_OFF |=> !o_shared_update_line_oe)
        else $error("Disabled update line is still driven.");

    conv_master_a: assert property (@(posedge i_tick_clk) disable iff (!i_nrst)
        t.c2.en && role_of(t.c2.roles, LINE_CONV) == ROLE_MASTER
        |=> o_shared_conversion_line_oe && o_shared_conversion_line == o_conversion_strobe)
        else $error("Conversion master does not drive its strobe out.");
endmodule

// [sim/daq_timing_sync_router_tb.sv]
// Purpose: Self-checking bench for the timing router.
// Assumes: The tick clock runs free at 30 ns, unrelated to the core clock.
// Notes: Tick-domain inputs change just after tick edges, except aext, which is set just after a core clock edge.
`timescale 1ns/1ns
module daq_timing_sync_router_tb;
    import daq_timing_pkg::*;
    typedef struct packed {logic [11:0] r; logic [1:0] ts; logic [1:0] ets;
        logic [5:0] eoe;} row_t;
    row_t rows [6] = '{'{12'h000, TICK_EXT, 2'h1, 6'h00}, '{12'h000, 2'h3, 2'h0, 6'h00},
        '{12'h002, TICK_INT, 2'h2, 6'h00}, '{12'h001, TICK_INT, 2'h0, 6'h01},
        '{12'h555, TICK_INT, 2'h0, 6'h3f}, '{12'h924, TICK_INT, 2'h0, 6'h12}};
    logic i_core_clk = 1'h0, i_tick_clk = 1'h0, i_nrst = 1'h0, en = 1'h1, aux1 = 1'h0;
    logic asw = 1'h0, osw = 1'h0, cload = 1'h0, csave = 1'h0, cdone = 1'h0, iconv = 1'h0;
    logic iscan = 1'h0, iupd = 1'h0, aan = 1'h0, oan = 1'h0, aext = 1'h0, oext = 1'h0;
    logic pin0 = 1'h0, pin1 = 1'h0, tick_oe, conv, scan, scen, upd, atrg, otrg, aecho, oecho;
    logic lreq, sreq, cval;
    logic [1:0] tsel = 2'h0, a0 = 2'h0, asel = 2'h0, osel = 2'h0, tmode = 2'h3, bank = 2'h0;
    logic [1:0] tsel_o, tmode_o, cbank;
    logic [11:0] roles = 12'h000;
    logic [DATE_W-1:0] date = 16'h0000, cdate;
    logic [TEMP_W-1:0] temp = 8'h00, ctemp;
    logic [4:0] sh_out, sh_oe, line;
    int fails = 0, comparisons = 0, n_conv = 0, n_scan = 0, n_upd = 0, n_shc = 0;
    daq_timing_sync_router u_daq_timing_sync_router (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
        .i_core_en(en), .i_tick_clk(i_tick_clk), .i_tick_sel(tsel), .i_sync_roles(roles),
        .i_aux0_mode(a0), .i_aux1_update(aux1), .i_acq_trig_sel(asel), .i_out_trig_sel(osel),
        .i_trig_mode(tmode), .i_acq_sw_trigger(asw), .i_out_sw_trigger(osw),
        .i_cal_bank_sel(bank), .i_cal_load(cload), .i_cal_save(csave), .i_cal_done(cdone),
        .i_cal_date(date), .i_cal_temp(temp), .i_int_conv(iconv), .i_int_scan(iscan),
        .i_int_update(iupd), .i_acq_analog_trig(aan), .i_out_analog_trig(oan),
        .i_aux_function_input({pin1, pin0}), .i_acq_ext_trigger_in(aext),
        .i_out_ext_trigger_in(oext), .i_shared_acq_trigger_line(line[0]),
        .i_shared_conversion_line(line[1]), .i_shared_scan_line(line[2]),
        .i_shared_out_trigger_line(line[3]), .i_shared_update_line(line[4]),
        .o_tick_select(tsel_o), .o_shared_tick_line_oe(tick_oe),
        .o_shared_acq_trigger_line(sh_out[0]), .o_shared_acq_trigger_line_oe(sh_oe[0]),
        .o_shared_conversion_line(sh_out[1]), .o_shared_conversion_line_oe(sh_oe[1]),
        .o_shared_scan_line(sh_out[2]), .o_shared_scan_line_oe(sh_oe[2]),
        .o_shared_out_trigger_line(sh_out[3]), .o_shared_out_trigger_line_oe(sh_oe[3]),
        .o_shared_update_line(sh_out[4]), .o_shared_update_line_oe(sh_oe[4]),
        .o_conversion_strobe(conv), .o_scan_begin(scan), .o_scan_counter_en(scen),
        .o_update_strobe(upd), .o_acq_trigger(atrg), .o_output_trigger(otrg),
        .o_trig_mode(tmode_o), .o_acq_trigger_echo(aecho), .o_out_trigger_echo(oecho),
        .o_cal_load_req(lreq), .o_cal_save_req(sreq), .o_cal_bank(cbank),
        .o_cal_date(cdate), .o_cal_temp(ctemp), .o_cal_valid(cval));
    peer_card_model u_peer_card_model (.i_tick_clk(i_tick_clk), .i_dev_out(sh_out),
        .i_dev_oe(sh_oe), .o_line(line));
    always #5 i_core_clk = ~i_core_clk;
    initial begin
        #7;
        forever #15 i_tick_clk = ~i_tick_clk;
    end
    always @(posedge i_tick_clk) begin
        n_conv += conv;
        n_scan += scan;
        n_upd += upd;
        n_shc += sh_out[1] & sh_oe[1];
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task core(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task tick(input int n);
        repeat (n) @(posedge i_tick_clk);
        #1;
    endtask
    task automatic pulse(ref logic s, input int n);
        s = 1'h1;
        tick(n);
        s = 1'h0;
        tick(4);
    endtask
    task settle;
        core(3);
        tick(4);
        n_conv = 0;
        n_scan = 0;
        n_upd = 0;
        n_shc = 0;
    endtask
    task done;
        cdone = 1'h1;
        core(1);
        cdone = 1'h0;
        core(1);
    endtask
    initial begin
        #50000;
        fails++;
        results;
    end
    initial begin
        core(3);
        check({tsel_o, sh_oe, tick_oe}, 8'h00);
        check({lreq, cval, cbank}, 4'h8);
        i_nrst = 1'h1;
        core(1);
        done;
        check({lreq, cval}, 2'h1);
        foreach (rows[i]) begin
            roles = rows[i].r;
            tsel = rows[i].ts;
            settle;
            check({tsel_o, sh_oe, tick_oe}, {rows[i].ets, rows[i].eoe});
        end
        bank = 2'h2;
        date = 16'h1234;
        temp = 8'h56;
        csave = 1'h1;
        core(1);
        csave = 1'h0;
        check({sreq, cbank, cdate, ctemp}, {1'h1, 2'h2, 16'h1234, 8'h56});
        done;
        bank = CAL_FACTORY_BANK;
        csave = 1'h1;
        core(1);
        csave = 1'h0;
        core(1);
        check(sreq, 1'h0);
        bank = 2'h3;
        cload = 1'h1;
        core(1);
        cload = 1'h0;
        check({lreq, cbank}, 3'h7);
        done;
        roles = 12'h000;
        a0 = AUX0_CONV;
        asel = TRIG_DIGITAL;
        aext = 1'h1;
        settle;
        pulse(iconv, 1);
        pulse(iscan, 1);
        pulse(pin0, 3);
        pulse(pin1, 3);
        pulse(pin0, 3);
        check({n_conv[3:0], n_scan[3:0], n_upd[3:0]}, 12'h200);
        check({scen, atrg, tmode_o}, 4'h0);
        aux1 = 1'h1;
        settle;
        pulse(iupd, 1);
        pulse(pin1, 3);
        check(n_upd, 1);
        aux1 = 1'h0;
        a0 = AUX0_SCAN;
        settle;
        pulse(pin0, 3);
        pulse(iconv, 1);
        check({n_conv[3:0], n_scan[3:0]}, 8'h11);
        a0 = AUX0_OFF;
        roles = 12'h010;
        settle;
        pulse(iconv, 1);
        check({n_conv[3:0], n_shc[3:0]}, 8'h11);
        check(scen, 1'h1);
        roles = 12'h020;
        settle;
        u_peer_card_model.drive_line(1, 1'h1, 1'h0);
        settle;
        u_peer_card_model.drive_line(1, 1'h1, 1'h1);
        tick(3);
        u_peer_card_model.drive_line(1, 1'h1, 1'h0);
        pulse(iconv, 1);
        check(n_conv, 1);
        u_peer_card_model.drive_line(0, 1'h1, 1'h1);
        roles = 12'h008;
        asel = TRIG_SW;
        settle;
        check({atrg, aecho}, 2'h3);
        for (int s = 0; s < 4; s++) begin
            tick(1);
            osel = s[1:0];
            osw = s == 0;
            oan = s == 1;
            oext = s == 2;
            roles = (s == 3) ? 12'h200 : 12'h000;
            u_peer_card_model.drive_line(3, 1'h1, s == 3);
            settle;
            check({otrg, oecho}, 2'h3);
        end
        check(u_peer_card_model.clash, 0);
        results;
    end
endmodule

// [sim/peer_card_model.sv]
// Purpose: Model of the other cards on the backplane trigger lines.
// Assumes: Line index 0 acq, 1 conversion, 2 scan, 3 out trigger, 4 update.
// Notes: A released line holds the inverse of its last driven level.
`timescale 1ns/1ns
module peer_card_model (
    input wire logic i_tick_clk,
    input wire logic [4:0] i_dev_out,
    input wire logic [4:0] i_dev_oe,
    output logic [4:0] o_line
);
    logic [4:0] drv = 5'h00;
    logic [4:0] val = 5'h00;
    logic [4:0] held = 5'h00;
    int clash = 0;
    // The device master drives first, then this card, else the line holds the inverse of its last driven level.
    assign o_line = (i_dev_oe & i_dev_out) | (~i_dev_oe & drv & val)
        | (~(i_dev_oe | drv) & ~held);
    always @(posedge i_tick_clk) begin
        held <= ((i_dev_oe | drv) & o_line) | (~(i_dev_oe | drv) & held);
        if (|(i_dev_oe & drv)) begin
            clash <= clash + 1;
        end
    end
    // This card takes or releases one line, called just after a tick edge.
    task drive_line(input int k, input logic d, input logic v);
        drv[k] = d;
        val[k] = v;
    endtask
endmodule
